// [sms_pkg.sv]
// Shared constants and types of the serial memory bus slave front end
package sms_pkg;

  // ==========================================================================
  // Select byte layout and counts
  // ==========================================================================
  localparam logic [3:0] SMS_DEV_TYPE_DEFAULT = 4'h5; // Arbitrary value, override per product
  localparam logic [3:0] SMS_LAST_BIT         = 4'h7;
  localparam logic [1:0] SMS_IDX_SELECT       = 2'h0;
  localparam logic [1:0] SMS_IDX_DATA         = 2'h3;
  localparam logic [3:0] SMS_PH_WAIT_FALL     = 4'h0;
  localparam logic [3:0] SMS_PH_DRIVE         = 4'h1;
  localparam logic [3:0] SMS_PH_RELEASE       = 4'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    SMS_STANDBY,
    SMS_RX,
    SMS_ACK,
    SMS_TX,
    SMS_MACK
  } sms_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       is_addr;
  } sms_rx_t;

  typedef struct packed {
    sms_state_t st;
    logic       scl_prev;
    logic       sda_prev;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic       rw;
    logic       ack_ok;
    logic       wr_armed;
    logic       sda_drive;
    sms_rx_t    rx;
    logic       tx_load;
    logic       write_start;
  } sms_regs_t;

  localparam sms_regs_t SMS_REGS_RESET = '0;

endpackage : sms_pkg

// [sms_front_end.sv]
// Two-wire serial memory bus slave front end
`timescale 1ns/1ps
// Notes on behaviour
// - Compare select bits b3..b1 with three straps
// - Floating strap reads as logic zero
// - Write protect high blocks all array writes
// - Protected: ack select/address, nack data bytes
// - Ignore bus until reset releases, then standby
// - Reset reasserted stops all bus responses
// - Stop enters standby, write cycle running or not
// - Start is SDA fall, SCL high; not busy
// - Stop is SDA rise, SCL high; ends transfer
// - Master nack returns to standby before any stop
// - Stop after write data launches write cycle
// - Transmitter releases SDA; receiver acks ninth clock
// - Sample SDA on rising SCL edge
// - Select byte MSB first; wrong type, no ack
// - Strap mismatch releases bus and goes standby
// - Select bit zero: one read, zero write
// - Matching select acked low in ninth bit
// - SDA driver is open drain only
// - Current-address read ignores write protect
// - Sequential read streams bytes, ignores protect
module sms_front_end #(
  parameter logic [3:0] DEV_TYPE = sms_pkg::SMS_DEV_TYPE_DEFAULT
) (
  // Clock and power-on reset
  input  wire logic           clk,
  input  wire logic           arst_n,
  // Two-wire bus pins
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  // Straps and protect pin, pulled down at the pad
  input  wire logic           chip_select_strap_high,
  input  wire logic           chip_select_strap_mid,
  input  wire logic           chip_select_strap_low,
  input  wire logic           write_protect_input,
  // Memory core side
  input  wire logic           write_busy,
  input  wire logic [7:0]     tx_data,
  output sms_pkg::sms_rx_t    rx,
  output logic                tx_load,
  output logic                write_start,
  output logic                read_mode,
  output logic                standby
);

  // ==========================================================================
  // State
  // ==========================================================================
  sms_pkg::sms_regs_t r;
  sms_pkg::sms_regs_t next_r;
  logic [1:0]         bus_s;
  logic [3:0]         pin_s;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Bus pins as {scl, sda}; edges are found one stage later in the main state
  sms_sync2 #(
    .WIDTH (2)
  ) i_sms_sync2_bus (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({scl_in, sda_in}),
    .q      (bus_s)
  );

  // Straps and protect change rarely, but still come from off chip
  sms_sync2 #(
    .WIDTH (4)
  ) i_sms_sync2_pins (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({write_protect_input, chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low}),
    .q      (pin_s)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic       scl;
    logic       sda;
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic       wp;
    logic [7:0] byte_v;
    logic       match;
    scl     = 1'b0;
    sda     = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    start_c = 1'b0;
    stop_c  = 1'b0;
    wp      = 1'b0;
    byte_v  = 8'h00;
    match   = 1'b0;
    next_r = r;
    next_r.rx.valid    = 1'b0;
    next_r.tx_load     = 1'b0;
    next_r.write_start = 1'b0;

    // Pins arrive here through the two-flop synchronisers
    scl = bus_s[1];
    sda = bus_s[0];
    next_r.scl_prev = scl;
    next_r.sda_prev = sda;

    rise    = scl & ~r.scl_prev;
    fall    = ~scl & r.scl_prev;
    start_c = scl & r.scl_prev & r.sda_prev & ~sda;
    stop_c  = scl & r.scl_prev & ~r.sda_prev & sda;
    wp      = pin_s[3];
    byte_v  = {r.shreg[6:0], sda};
    // Unconnected straps rely on the pad pull-down so they compare as zero
    match   = (byte_v[7:4] == DEV_TYPE) && (byte_v[3:1] == pin_s[2:0]);

    // A busy array is deaf to starts, so ack polling sees no answer
    if (start_c && !write_busy) begin
      next_r.st        = sms_pkg::SMS_RX;
      next_r.bit_cnt   = '0;
      next_r.byte_idx  = sms_pkg::SMS_IDX_SELECT;
      next_r.sda_drive = 1'b0;
      next_r.wr_armed  = 1'b0;
    end else if (stop_c) begin
      // Protect raised after the last ack still cancels the write
      next_r.write_start = r.wr_armed & ~wp;
      next_r.st          = sms_pkg::SMS_STANDBY;
      next_r.sda_drive   = 1'b0;
      next_r.wr_armed    = 1'b0;
    end else begin
      case (r.st)
        sms_pkg::SMS_STANDBY: begin
          next_r.sda_drive = 1'b0;
        end
        sms_pkg::SMS_RX: begin
          if (rise) begin
            next_r.shreg    = byte_v;
            next_r.bit_cnt  = r.bit_cnt + 4'h1;
            // A stop after an acked data byte needs one more SCL high phase
            if (r.bit_cnt != 4'h0) begin
              next_r.wr_armed = 1'b0;
            end
            if (r.bit_cnt == sms_pkg::SMS_LAST_BIT) begin
              next_r.bit_cnt = sms_pkg::SMS_PH_WAIT_FALL;
              next_r.st      = sms_pkg::SMS_ACK;
              if (r.byte_idx == sms_pkg::SMS_IDX_SELECT) begin
                next_r.ack_ok = match;
                next_r.rw     = byte_v[0];
                if (!match) begin
                  next_r.st = sms_pkg::SMS_STANDBY;
                end
              end else if (r.byte_idx == sms_pkg::SMS_IDX_DATA) begin
                next_r.ack_ok   = ~wp;
                next_r.rx.valid = ~wp;
              end else begin
                next_r.ack_ok   = 1'b1;
                next_r.rx.valid = 1'b1;
              end
              next_r.rx.data    = byte_v;
              next_r.rx.is_addr = (r.byte_idx != sms_pkg::SMS_IDX_DATA);
            end
          end
        end
        sms_pkg::SMS_ACK: begin
          if (fall && r.bit_cnt == sms_pkg::SMS_PH_WAIT_FALL) begin
            next_r.sda_drive = r.ack_ok;
            next_r.bit_cnt   = sms_pkg::SMS_PH_DRIVE;
          end else if (rise && r.bit_cnt == sms_pkg::SMS_PH_DRIVE) begin
            next_r.bit_cnt = sms_pkg::SMS_PH_RELEASE;
          end else if (fall && r.bit_cnt == sms_pkg::SMS_PH_RELEASE) begin
            next_r.bit_cnt = '0;
            if (r.byte_idx == sms_pkg::SMS_IDX_SELECT && r.rw) begin
              next_r.st        = sms_pkg::SMS_TX;
              next_r.shreg     = tx_data;
              next_r.tx_load   = 1'b1;
              next_r.sda_drive = ~tx_data[7];
            end else begin
              next_r.st        = sms_pkg::SMS_RX;
              next_r.sda_drive = 1'b0;
              next_r.wr_armed  = (r.byte_idx == sms_pkg::SMS_IDX_DATA) && r.ack_ok;
              if (r.byte_idx != sms_pkg::SMS_IDX_DATA) begin
                next_r.byte_idx = r.byte_idx + 2'h1;
              end
            end
          end
        end
        sms_pkg::SMS_TX: begin
          if (rise) begin
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            if (r.bit_cnt == sms_pkg::SMS_LAST_BIT) begin
              next_r.st      = sms_pkg::SMS_MACK;
              next_r.bit_cnt = sms_pkg::SMS_PH_WAIT_FALL;
            end
          end else if (fall) begin
            // Data only moves while SCL is low
            next_r.shreg     = {r.shreg[6:0], 1'b0};
            next_r.sda_drive = ~r.shreg[6];
          end
        end
        sms_pkg::SMS_MACK: begin
          if (fall && r.bit_cnt == sms_pkg::SMS_PH_WAIT_FALL) begin
            next_r.sda_drive = 1'b0;
            next_r.bit_cnt   = sms_pkg::SMS_PH_DRIVE;
          end else if (rise && r.bit_cnt == sms_pkg::SMS_PH_DRIVE) begin
            if (sda) begin
              next_r.st = sms_pkg::SMS_STANDBY;
            end else begin
              next_r.bit_cnt = sms_pkg::SMS_PH_RELEASE;
            end
          end else if (fall && r.bit_cnt == sms_pkg::SMS_PH_RELEASE) begin
            next_r.st        = sms_pkg::SMS_TX;
            next_r.bit_cnt   = '0;
            next_r.shreg     = tx_data;
            next_r.tx_load   = 1'b1;
            next_r.sda_drive = ~tx_data[7];
          end
        end
        default: begin
          next_r.st        = sms_pkg::SMS_STANDBY;
          next_r.sda_drive = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Power-on reset holds everything quiet and releases into standby
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= sms_pkg::SMS_REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign sda_out     = 1'b0;
  assign sda_oe      = r.sda_drive;
  assign rx          = r.rx;
  assign tx_load     = r.tx_load;
  assign write_start = r.write_start;
  assign read_mode   = r.rw;
  assign standby     = (r.st == sms_pkg::SMS_STANDBY);

endmodule : sms_front_end

// ============================================================================
// Two-flop synchroniser for levels from outside the clock domain
// ============================================================================
module sms_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Asynchronous levels in, settled levels out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sms_sync_regs_t;

  sms_sync_regs_t r;
  sms_sync_regs_t next_r;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Only the second stage is read, so a metastable first stage never reaches logic
  always_comb begin
    next_r        = r;
    next_r.meta   = d;
    next_r.stable = r.meta;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign q = r.stable;

endmodule : sms_sync2

// [sms_front_end_chk_sva.sv]
// Assertion checker for the two-wire slave front end
`timescale 1ns/1ps
module sms_front_end_chk (
  // Clock, reset and bus
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             scl_in,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  // Protect and core side
  input wire logic             write_protect_input,
  input wire logic             write_busy,
  input wire sms_pkg::sms_rx_t rx,
  input wire logic             tx_load,
  input wire logic             write_start,
  input wire logic             read_mode,
  input wire logic             standby
);
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_sda_pull_only: assert property (!sda_out) else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  a_oe_not_standby: assert property (sda_oe |-> !standby) else $error("bus held in standby");
  a_busy_no_start: assert property (write_busy && standby |=> standby) else $error("start taken while busy");
  a_ws_protect: assert property (write_start |-> !write_protect_input) else $error("write under protect");
  a_ws_on_stop: assert property (write_start |-> scl_in && sda_in) else $error("write not on stop");
  a_ws_pulse: assert property (write_start |=> !write_start [*2]) else $error("write start repeated");
  a_ws_standby: assert property (write_start |-> ##[0:2] standby) else $error("no standby after stop");
  a_rx_data_prot: assert property (rx.valid && !rx.is_addr |-> !write_protect_input) else $error("data under protect");
  a_rx_write_only: assert property (rx.valid |-> !read_mode) else $error("byte taken in read");
  a_tx_load_read: assert property (tx_load |-> read_mode && !scl_in) else $error("load outside read");
endmodule : sms_front_end_chk

bind sms_front_end sms_front_end_chk i_sms_front_end_chk (.clk, .arst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
  .write_protect_input, .write_busy, .rx, .tx_load, .write_start, .read_mode, .standby);

// [sms_bus_master.sv]
// Behavioural two-wire bus master facing the front end
`timescale 1ns/1ps
module sms_bus_master (
  // Clock and bus
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  // ==========================================================
  // Bus cycles, quarter period of 40 ns
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hq();
    repeat (2) @(negedge clk);
  endtask : hq
  // Data moves mid low phase, so no false start or stop is seen
  task automatic clk_bit(input logic b, output logic s);
    scl = 1'b0;
    hq();
    sda_m = b;
    hq();
    scl = 1'b1;
    repeat (2) hq();
    s = sda;
  endtask : clk_bit
  task automatic start();
    logic s;
    clk_bit(1'b1, s);
    sda_m = 1'b0;
    repeat (2) hq();
  endtask : start
  task automatic stop();
    logic s;
    clk_bit(1'b0, s);
    sda_m = 1'b1;
    repeat (4) hq();
  endtask : stop
  // Sending 1 releases the line, so reads pass d of all ones
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], q[i]);
    clk_bit(mack, s);
    ack = !s;
  endtask : xfer
endmodule : sms_bus_master

// [test_sms_front_end.sv]
// Self-checking bench for the two-wire slave front end
`timescale 1ns/1ps
module test_sms_front_end;
  // ==========================================================
  // Signals and instances
  localparam logic [3:0] DEV = 4'h6; // Arbitrary type code
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [2:0]       strap = 3'h5;
  logic             write_protect_input = 1'b0;
  logic             write_busy = 1'b0;
  logic [7:0]       tx_data = 8'ha5;
  logic [7:0]       q;
  logic [7:0]       last_rx = 8'h00;
  logic             last_addr = 1'b0;
  logic             scl, sda_m, sda_oe, sda_out, tx_load, write_start, read_mode, standby, ack;
  sms_pkg::sms_rx_t rx;
  int               errors = 0, n_checks = 0, cyc = 0, n_ws = 0;
  wire              sda = sda_m & (sda_oe ? sda_out : 1'b1);
  always #10 clk = ~clk;
  sms_bus_master i_sms_bus_master (.clk, .sda, .scl, .sda_m);
  sms_front_end #(.DEV_TYPE(DEV)) i_sms_front_end (.clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .chip_select_strap_high(strap[2]), .chip_select_strap_mid(strap[1]), .chip_select_strap_low(strap[0]),
    .write_protect_input, .write_busy, .tx_data, .rx, .tx_load, .write_start, .read_mode, .standby);
  // Memory core stand-in: next byte after each load, driven off the sampling edge
  always @(negedge clk) begin
    cyc++;
    if (tx_load)
      tx_data <= tx_data - 8'h01;
    if (rx.valid) begin
      last_rx   <= rx.data;
      last_addr <= rx.is_addr;
    end
    if (write_start)
      n_ws++;
    if (cyc == 10000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task automatic sel(input logic [7:0] code, input logic exp);
    i_sms_bus_master.start();
    i_sms_bus_master.xfer(code, 1'b1, q, ack);
    chk("select ack", {7'h00, exp}, {7'h00, ack});
  endtask : sel
  task automatic wr(input logic [7:0] d, input logic exp);
    i_sms_bus_master.xfer(d, 1'b1, q, ack);
    chk("byte ack", {7'h00, exp}, {7'h00, ack});
  endtask : wr
  task automatic rd(input logic [7:0] exp, input logic mack);
    i_sms_bus_master.xfer(8'hff, mack, q, ack);
    chk("read byte", exp, q);
  endtask : rd
  task automatic summarize();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Sequence
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    sel({DEV, strap, 1'b0}, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h02, 1'b1);
    wr(8'h3c, 1'b1);
    i_sms_bus_master.stop();
    chk("data byte", 8'h3c, last_rx);
    chk("write starts", 8'h01, n_ws[7:0]);
    chk("standby", 8'h01, {7'h00, standby});
    chk("address flag", 8'h00, {7'h00, last_addr});
    write_protect_input = 1'b1;
    sel({DEV, strap, 1'b0}, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h02, 1'b1);
    wr(8'h77, 1'b0);
    i_sms_bus_master.stop();
    chk("write starts", 8'h01, n_ws[7:0]);
    chk("data byte", 8'h02, last_rx);
    chk("address flag", 8'h01, {7'h00, last_addr});
    sel({DEV, strap, 1'b1}, 1'b1);
    rd(8'ha5, 1'b0);
    rd(8'ha4, 1'b1);
    chk("standby", 8'h01, {7'h00, standby});
    i_sms_bus_master.stop();
    write_protect_input = 1'b0;
    sel({DEV ^ 4'h8, strap, 1'b0}, 1'b0);
    for (int k = 0; k < 3; k++)
      sel({DEV, strap ^ (3'h1 << k), 1'b0}, 1'b0);
    chk("standby", 8'h01, {7'h00, standby});
    strap = 3'h0;
    sel({DEV, 3'h0, 1'b0}, 1'b1);
    repeat (3)
      i_sms_bus_master.clk_bit(1'b0, ack);
    sel({DEV, 3'h0, 1'b1}, 1'b1);
    chk("read mode", 8'h01, {7'h00, read_mode});
    rd(8'ha3, 1'b1);
    i_sms_bus_master.stop();
    write_busy = 1'b1;
    sel({DEV, 3'h0, 1'b0}, 1'b0);
    chk("standby", 8'h01, {7'h00, standby});
    i_sms_bus_master.stop();
    write_busy = 1'b0;
    sel({DEV, 3'h0, 1'b0}, 1'b1);
    arst_n = 1'b0;
    wr(8'h01, 1'b0);
    arst_n = 1'b1;
    i_sms_bus_master.stop();
    chk("standby", 8'h01, {7'h00, standby});
    sel({DEV, 3'h0, 1'b0}, 1'b1);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    wr(8'h55, 1'b1);
    write_protect_input = 1'b1;
    i_sms_bus_master.stop();
    chk("write starts", 8'h01, n_ws[7:0]);
    chk("data byte", 8'h55, last_rx);
    write_protect_input = 1'b0;
    summarize();
  end
endmodule : test_sms_front_end
